/* File: hw/adc_host_pkg.sv */
package adc_host_pkg;
  // Bus field positions
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 6;
  localparam int FUNC_LSB = 6;
  localparam int FUNC_W = 3;
  localparam int EXC_BIT = 11;
  localparam int DTI_BIT = 13;
  localparam int DTO_BIT = 14;
  localparam int DATA_W = 16;
  localparam int RES_W = 13;
  // Function codes
  localparam logic [2:0] FUNC_BIC_ENABLE = 3'h0;
  localparam logic [2:0] FUNC_START = 3'h1;
  localparam logic [2:0] FUNC_PROGRAM = 3'h2;
  localparam logic [2:0] SENSE_DATA = 3'h0;
  localparam logic [2:0] SENSE_TIMER = 3'h1;
  // Conversion and timer constants
  localparam int SEQ_CLOCKS = 12;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int ZERO_PULSE_PS = 100000;
  localparam int ZERO_PULSE_CYC = (ZERO_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TICK_STD_PS = 1000000;
  localparam int TICK_STD_CYC = TICK_STD_PS / CLK_PERIOD_PS;
  // Request kinds on the host side
  typedef enum logic [1:0] {
    REQ_EXC = 2'b00,
    REQ_SENSE = 2'b01,
    REQ_DTI = 2'b10,
    REQ_DTO = 2'b11
  } req_kind_t;
endpackage : adc_host_pkg

/* File: hw/adc_link_if.sv */
`timescale 1ns/1ps
// Processor I/O bus and block-transfer controller link
interface adc_link_if;
  logic [15:0] bus_out;        // Host to device word
  logic [15:0] bus_in;         // Device to host word
  logic bus_in_oe;             // Device drives bus_in
  logic function_strobe;       // Latches function code
  logic data_out_strobe;       // Loads timer buffer
  logic sense_strobe;          // Sense instruction pulse
  logic sense_response_line;   // Sense answer
  logic connect_request;       // Controller connect request
  logic connected_indication;  // Device reports connection
  logic disconnect_request;    // Controller disconnect
  logic transfer_request;      // Device asks for a word
  logic transfer_take;         // Controller takes the word
  modport device (input bus_out, function_strobe, data_out_strobe, sense_strobe,
    connect_request, disconnect_request, transfer_take,
    output bus_in, bus_in_oe, sense_response_line, connected_indication, transfer_request);
  modport host (output bus_out, function_strobe, data_out_strobe, sense_strobe,
    connect_request, disconnect_request, transfer_take,
    input bus_in, bus_in_oe, sense_response_line, connected_indication, transfer_request);
endinterface : adc_link_if

/* File: hw/adc_device.sv */
`timescale 1ns/1ps
// Behaviour
// R1: Host starts with address, code 1, bit 11
// R2: Start decode sets hold flop
// R3: Busy clocks sequencer, last clock gives store
// R4: Store sets sample; LSB then latched
// R5: Store sets data-ready until transfer in
// R6: Sense 0 answers data-ready on response line
// R7: Bit 13 sets transfer-in, enabling output
// R8: Result bits 0-11, sign on 12-15
// R9: Two's complement, 007777 to 170000
// R10: Output enable clears data-ready
// R11: Code 2 sets program, routes start source
// R12: Code 0 sets block-transfer enable
// R13: Connect sets connected until disconnect
// R14: Connected and ready raise request; take outputs
// R15: Disconnect clears enable and program flops
// R16: 16-bit down timer, 100 ns zero pulse
// R17: Bit 14 plus data strobe loads buffer
// R18: Timer decrements once per tick
// R19: Continuous reloads; single-cycle needs input
// R20: Zero clears status; sense sets synced flag
// R21: Timer load sets status and clears sense flag
// R22: Zero pulse may drive conversion start
// R23: Thirteen bits, sign first, twelve clocks
// R24: Reset clears flags, start logic samples; timer status flag resets high
module adc_device #(
  parameter logic [5:0] DEVICE_ADDR = 6'h30,
  parameter int TICK_CYC = adc_host_pkg::TICK_STD_CYC
) (
  input wire logic clock,
  input wire logic rst,
  adc_link_if.device link,
  input wire logic comparator_in,
  input wire logic external_start,
  input wire logic single_cycle_reload_input,
  input wire logic continuous_mode,
  input wire logic timer_start_jumper,
  output logic hold_n,
  output logic busy,
  output logic timer_zero_pulse_n
);
  import adc_host_pkg::*;

  // Conversion states
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_BUSY = 2'b10
  } conv_state_t;

  conv_state_t state_reg;                 // Start logic state
  logic [3:0] seq_reg;                    // Sequencing clock count
  logic [RES_W-1:0] sar_reg;              // Approximation flops
  logic [RES_W-1:0] result_reg;           // Data buffer
  logic data_ready_reg;                   // Data sense flop
  logic program_reg;                      // Program flop
  logic bic_enable_reg;                   // Block-transfer enable
  logic connected_reg;                    // Connected flop
  logic out_reg;                          // Output enable pulse
  logic [15:0] bus_reg;                   // Driven word
  logic sense_reg;                        // Sense response
  logic req_reg;                          // Transfer request
  logic transfer_out_reg;                 // Transfer-out flop, armed by bit 14
  logic [DATA_W-1:0] timer_buf_reg;       // Timer load buffer
  logic [DATA_W-1:0] timer_cnt_reg;       // Down counter
  logic [$clog2(TICK_CYC+1)-1:0] tick_reg; // Tick prescaler
  logic [4:0] zero_cnt_reg;               // Zero pulse width
  logic timer_status_reg;                 // High until expiry
  logic timer_sense_reg;                  // Synchronised sense flag
  logic sense_t_arm_reg;                  // Timer sense seen
  logic [1:0] ext_sync_reg;               // External start synchroniser
  logic [1:0] rel_sync_reg;               // Reload input synchroniser
  logic [1:0] cmp_sync_reg;               // Comparator synchroniser
  logic ext_prev_reg;                     // External start edge memory
  logic zero_prev_reg;                    // Zero pulse edge memory

  // Decoding of the bus
  wire addressed = link.bus_out[ADDR_W-1:0] == DEVICE_ADDR;
  wire [2:0] func = link.bus_out[FUNC_LSB +: FUNC_W];
  wire exc_cmd = link.function_strobe && addressed && link.bus_out[EXC_BIT];
  wire start_decode = exc_cmd && func == FUNC_START;          // see R2
  wire program_decode = exc_cmd && func == FUNC_PROGRAM;      // see R11
  wire enable_decode = exc_cmd && func == FUNC_BIC_ENABLE;    // see R12
  wire dti_cmd = link.function_strobe && addressed && link.bus_out[DTI_BIT]; // see R7
  wire dto_cmd = link.function_strobe && addressed && link.bus_out[DTO_BIT]; // see R17
  wire timer_load = link.data_out_strobe && transfer_out_reg; // Data word, see R17
  wire sense_data = link.sense_strobe && addressed && func == SENSE_DATA;
  wire sense_timer = link.sense_strobe && addressed && func == SENSE_TIMER;
  wire tick_done = tick_reg == '0;
  wire zero_now = timer_cnt_reg == '0 && zero_cnt_reg == '0 && tick_done;
  wire zero_rise = zero_cnt_reg != '0 && !zero_prev_reg;
  wire ext_rise = ext_sync_reg[1] && !ext_prev_reg;
  wire auto_start = program_reg &&
    ((timer_start_jumper && zero_rise) || (!timer_start_jumper && ext_rise)); // see R22
  wire store = state_reg == ST_BUSY && seq_reg == 4'(SEQ_CLOCKS - 1);  // see R3
  wire take = connected_reg && link.transfer_take;             // see R14
  wire out_en = dti_cmd || take;
  wire disconnect = connected_reg && link.disconnect_request;  // see R15
  wire [15:0] word = {{(DATA_W-RES_W){result_reg[RES_W-1]}}, result_reg}; // see R8 R9

  // Start logic and approximation register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ST_SAMPLE;  // see R24
      seq_reg <= '0;
      sar_reg <= '0;
      result_reg <= '0;
    end else begin
      case (state_reg)
        ST_SAMPLE: begin
          seq_reg <= '0;
          if (start_decode || auto_start) state_reg <= ST_HOLD;  // see R2 R11
        end
        ST_HOLD: begin
          state_reg <= ST_BUSY;                 // see R3
          sar_reg <= {!cmp_sync_reg[1], 12'h000}; // Sign first; positive gives 0, see R9 R23
        end
        ST_BUSY: begin
          sar_reg[RES_W-2-seq_reg] <= cmp_sync_reg[1]; // One bit per clock, see R23
          seq_reg <= seq_reg + 4'h1;
          if (store) begin
            state_reg <= ST_SAMPLE;             // see R4
            result_reg <= {sar_reg[RES_W-1:1], cmp_sync_reg[1]};
          end
        end
        default: state_reg <= ST_SAMPLE;
      endcase
    end
  end

  // Flags of the host interface
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_ready_reg <= 1'b0;
      program_reg <= 1'b0;
      bic_enable_reg <= 1'b0;
      connected_reg <= 1'b0;
    end else begin
      if (store) data_ready_reg <= 1'b1;          // Set wins, see R5
      else if (out_en) data_ready_reg <= 1'b0;    // see R10
      if (disconnect) begin
        program_reg <= 1'b0;                      // see R15
        bic_enable_reg <= 1'b0;
        connected_reg <= 1'b0;                    // see R13
      end else begin
        if (program_decode) program_reg <= 1'b1;  // see R11
        if (enable_decode) bic_enable_reg <= 1'b1; // see R12
        if (bic_enable_reg && link.connect_request) connected_reg <= 1'b1; // see R13
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_reg <= 1'b0;
      bus_reg <= '0;
      sense_reg <= 1'b0;
      req_reg <= 1'b0;
    end else begin
      out_reg <= out_en;                                 // see R7 R14
      bus_reg <= out_en ? word : '0;                     // see R8
      sense_reg <= (sense_data && data_ready_reg) ||
                   (sense_timer && timer_sense_reg);     // see R6
      req_reg <= connected_reg && data_ready_reg && !out_en; // see R14
    end
  end

  // Timer: prescaler, counter, zero pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_reg <= '0;
      timer_cnt_reg <= '0;
      timer_buf_reg <= '0;
      zero_cnt_reg <= '0;
      zero_prev_reg <= 1'b0;
      transfer_out_reg <= 1'b0;
    end else begin
      if (timer_load) transfer_out_reg <= 1'b0;        // One data word per arm
      else if (dto_cmd) transfer_out_reg <= 1'b1;      // see R17
      zero_prev_reg <= zero_cnt_reg != '0;
      tick_reg <= tick_done ? $bits(tick_reg)'(TICK_CYC - 1) : tick_reg - 1'b1; // see R18
      if (zero_cnt_reg != '0) zero_cnt_reg <= zero_cnt_reg - 5'h1;
      if (timer_load) begin
        timer_buf_reg <= link.bus_out;                   // see R17
        timer_cnt_reg <= link.bus_out;
      end else if (zero_now) begin
        zero_cnt_reg <= 5'(ZERO_PULSE_CYC);              // see R16
        if (continuous_mode || rel_sync_reg[1]) timer_cnt_reg <= timer_buf_reg; // see R19
      end else if (tick_done && timer_cnt_reg != '0) begin
        timer_cnt_reg <= timer_cnt_reg - 16'h0001;       // see R16 R18
      end
    end
  end

  // Timer status and synchronised sense flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_status_reg <= 1'b1;
      timer_sense_reg <= 1'b0;
      sense_t_arm_reg <= 1'b0;
    end else begin
      sense_t_arm_reg <= sense_timer;
      if (timer_load) begin
        timer_status_reg <= 1'b1;                        // see R21
        timer_sense_reg <= 1'b0;
      end else begin
        if (zero_now) timer_status_reg <= 1'b0;          // see R20
        if (sense_t_arm_reg && !sense_timer && !timer_status_reg)
          timer_sense_reg <= 1'b1;                       // Trailing edge, see R20
      end
    end
  end

  // Synchronisers for pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_sync_reg <= '0;
      rel_sync_reg <= '0;
      cmp_sync_reg <= '0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], external_start};
      rel_sync_reg <= {rel_sync_reg[0], single_cycle_reload_input};
      cmp_sync_reg <= {cmp_sync_reg[0], comparator_in};
      ext_prev_reg <= ext_sync_reg[1];
    end
  end

  // Pin outputs straight from flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_n <= 1'b1;
      busy <= 1'b0;
      timer_zero_pulse_n <= 1'b1;
    end else begin
      hold_n <= state_reg == ST_SAMPLE && !(start_decode || auto_start);
      busy <= state_reg == ST_HOLD || (state_reg == ST_BUSY && !store); // see R3
      timer_zero_pulse_n <= !(zero_now || zero_cnt_reg > 5'h1);
    end
  end

  assign link.bus_in = bus_reg;
  assign link.bus_in_oe = out_reg;
  assign link.sense_response_line = sense_reg;
  assign link.connected_indication = connected_reg;  // see R13
  assign link.transfer_request = req_reg;
endmodule : adc_device

/* File: hw/adc_host.sv */
`timescale 1ns/1ps
// Host and controller end: turns user requests into bus pulses
module adc_host #(
  parameter logic [5:0] DEVICE_ADDR = 6'h30
) (
  input wire logic clock,
  input wire logic rst,
  adc_link_if.host link,
  input wire logic req_valid,
  input wire adc_host_pkg::req_kind_t req_kind,
  input wire logic [15:0] req_data,
  output logic req_ready,
  input wire logic bic_connect,
  input wire logic bic_disconnect,
  output logic word_valid,
  output logic [15:0] word_data,
  input wire logic word_ready,
  output logic sense_valid,
  output logic sense_value,
  output logic connected
);
  import adc_host_pkg::*;

  logic [15:0] bus_reg;          // Bus word
  logic fs_reg, ds_reg, ss_reg;  // Strobes
  logic dce_reg, des_reg, tak_reg;
  logic sense_wait_reg;          // Awaiting sense answer
  logic dto_pend_reg;            // Timer word still to send
  logic [15:0] dto_data_reg;     // Timer word held for the data strobe
  logic [15:0] buf_reg [2];      // Two-entry word buffer
  logic [1:0] cnt_reg;
  logic wp_reg, rp_reg;

  wire [15:0] addr_word = {10'h000, DEVICE_ADDR};
  wire buf_full = cnt_reg == 2'h2;
  wire push = link.bus_in_oe;
  wire pop = word_valid && word_ready;
  wire issue = req_valid && req_ready;

  // Request sequencer, one strobe pulse per request, plus a data strobe pulse for REQ_DTO
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_reg <= '0;
      {fs_reg, ds_reg, ss_reg, dce_reg, des_reg, tak_reg} <= '0;
      req_ready <= 1'b0;
      sense_wait_reg <= 1'b0;
      dto_pend_reg <= 1'b0;
      dto_data_reg <= '0;
    end else begin
      {fs_reg, ds_reg, ss_reg, des_reg, tak_reg} <= '0;
      req_ready <= !issue && !sense_wait_reg && !dto_pend_reg && cnt_reg == 2'h0;
      if (issue) begin
        case (req_kind)
          REQ_EXC: begin            // see R1 R11 R12
            bus_reg <= addr_word | {req_data[15:6], 6'h00} | (16'h0001 << EXC_BIT);
            fs_reg <= 1'b1;
          end
          REQ_SENSE: begin
            bus_reg <= addr_word | {req_data[15:6], 6'h00};
            ss_reg <= 1'b1;
            sense_wait_reg <= 1'b1;
          end
          REQ_DTI: begin
            bus_reg <= addr_word | (16'h0001 << DTI_BIT);
            fs_reg <= 1'b1;
          end
          REQ_DTO: begin            // Select first, data next cycle, see R17
            bus_reg <= addr_word | (16'h0001 << DTO_BIT);
            fs_reg <= 1'b1;
            dto_pend_reg <= 1'b1;
            dto_data_reg <= req_data;
          end
          default: bus_reg <= '0;
        endcase
      end else if (sense_wait_reg && !ss_reg) begin
        sense_wait_reg <= 1'b0;
      end
      if (dto_pend_reg) begin       // Timer word with data strobe, see R17
        bus_reg <= dto_data_reg;
        ds_reg <= 1'b1;
        dto_pend_reg <= 1'b0;
      end
      if (bic_connect && !link.connected_indication) dce_reg <= 1'b1;  // see R13
      else if (link.connected_indication) dce_reg <= 1'b0;
      if (bic_disconnect && link.connected_indication) des_reg <= 1'b1;
      if (link.transfer_request && !tak_reg && !buf_full) tak_reg <= 1'b1; // see R14
    end
  end

  // Bus word: address and code, or the timer word during the data strobe
  assign link.bus_out = bus_reg;

  // Sense answer capture and word buffer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sense_valid <= 1'b0;
      sense_value <= 1'b0;
      cnt_reg <= '0;
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      connected <= 1'b0;
    end else begin
      connected <= link.connected_indication;
      sense_valid <= sense_wait_reg && !ss_reg;
      sense_value <= link.sense_response_line;
      if (push && !buf_full) begin
        buf_reg[wp_reg] <= link.bus_in;
        wp_reg <= !wp_reg;
      end
      if (pop) rp_reg <= !rp_reg;
      cnt_reg <= cnt_reg + 2'((push && !buf_full) ? 1 : 0) - 2'(pop ? 1 : 0);
    end
  end

  assign word_valid = cnt_reg != 2'h0;
  assign word_data = buf_reg[rp_reg];
  assign link.function_strobe = fs_reg;
  assign link.data_out_strobe = ds_reg;
  assign link.sense_strobe = ss_reg;
  assign link.connect_request = dce_reg;
  assign link.disconnect_request = des_reg;
  assign link.transfer_take = tak_reg;
endmodule : adc_host

/* File: sim/adc_link_props.sv */
`timescale 1ns/1ps
// Watches the link between the two ends
module adc_link_props #(
  parameter logic [5:0] DEVICE_ADDR = 6'h30
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] bus_out,
  input wire logic [15:0] bus_in,
  input wire logic bus_in_oe,
  input wire logic function_strobe,
  input wire logic sense_strobe,
  input wire logic sense_response_line,
  input wire logic disconnect_request,
  input wire logic connected_indication,
  input wire logic transfer_request,
  input wire logic transfer_take,
  input wire logic hold_n,
  input wire logic busy,
  input wire logic timer_zero_pulse_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Addressed start instruction on the bus
  wire logic start_hit = function_strobe && bus_out[5:0] == DEVICE_ADDR &&
    bus_out[8:6] == 3'h1 && bus_out[11];
  a_start_sets_hold: assert property (start_hit && hold_n && !busy |=> !hold_n)
    else $error("start did not lower hold");
  a_hold_then_busy: assert property ($fell(hold_n) |=> busy)
    else $error("busy did not follow hold");
  a_busy_length: assert property ($rose(busy) |-> busy [*8] ##1 busy [*4] ##1 !busy)
    else $error("bit clocking length wrong");
  a_sense_cause: assert property (sense_response_line |-> $past(sense_strobe))
    else $error("sense answer without strobe");
  a_oe_cause: assert property (bus_in_oe |-> $past(function_strobe || transfer_take))
    else $error("output enable without cause");
  a_sign_copies: assert property (bus_in_oe |-> bus_in[15:12] == {4{bus_in[12]}})
    else $error("sign bits differ");
  a_take_gates: assert property (transfer_take |=> bus_in_oe)
    else $error("take gave no word");
  a_request_stands: assert property (transfer_request && !transfer_take |=> transfer_request)
    else $error("request dropped before take");
  a_connect_holds: assert property (connected_indication && !disconnect_request
    |=> connected_indication)
    else $error("connection lost");
  a_disconnect_clears: assert property (disconnect_request |=> !connected_indication)
    else $error("disconnect ignored");
  a_zero_width: assert property ($fell(timer_zero_pulse_n) |->
    !timer_zero_pulse_n [*8] ##[5:6] timer_zero_pulse_n)
    else $error("zero pulse width wrong");
endmodule : adc_link_props

/* File: sim/test_adc_host_interface_timer.sv */
`timescale 1ns/1ps
// Counts one comparison and reports a mismatch
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
// Both ends joined over the link, driven from the host user side
module test_adc_host_interface_timer;
  import adc_host_pkg::*;
  logic clock, rst, comparator_in, external_start, single_cycle_reload_input;
  logic continuous_mode, timer_start_jumper, hold_n, busy, timer_zero_pulse_n;
  logic req_valid, req_ready, bic_connect, bic_disconnect, word_valid, word_ready;
  logic sense_valid, sense_value, connected;
  req_kind_t req_kind;
  logic [15:0] req_data, word_data, w_exp;
  logic s_exp;
  logic [15:0] exp_word[$]; // Words still owed by the design
  logic exp_sense[$]; // Sense answers still owed
  int err_count, n_tests, cycles, t, i;
  adc_link_if link_bus();
  adc_device #(.TICK_CYC(2)) i_adc_device (.clock(clock), .rst(rst), .link(link_bus),
    .comparator_in(comparator_in), .external_start(external_start),
    .single_cycle_reload_input(single_cycle_reload_input), .continuous_mode(continuous_mode),
    .timer_start_jumper(timer_start_jumper), .hold_n(hold_n), .busy(busy),
    .timer_zero_pulse_n(timer_zero_pulse_n));
  adc_host i_adc_host (.clock(clock), .rst(rst), .link(link_bus), .req_valid(req_valid),
    .req_kind(req_kind), .req_data(req_data), .req_ready(req_ready),
    .bic_connect(bic_connect), .bic_disconnect(bic_disconnect), .word_valid(word_valid),
    .word_data(word_data), .word_ready(word_ready), .sense_valid(sense_valid),
    .sense_value(sense_value), .connected(connected));
  adc_link_props i_adc_link_props (.clock(clock), .rst(rst), .bus_out(link_bus.bus_out),
    .bus_in(link_bus.bus_in), .bus_in_oe(link_bus.bus_in_oe),
    .function_strobe(link_bus.function_strobe), .sense_strobe(link_bus.sense_strobe),
    .sense_response_line(link_bus.sense_response_line),
    .disconnect_request(link_bus.disconnect_request),
    .connected_indication(link_bus.connected_indication),
    .transfer_request(link_bus.transfer_request), .transfer_take(link_bus.transfer_take),
    .hold_n(hold_n), .busy(busy), .timer_zero_pulse_n(timer_zero_pulse_n));
  // Free running clock, 8 ns period
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  // Prints counts and verdict, then stops
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  // One request, held until the host accepts it
  task automatic send(input req_kind_t k, input logic [15:0] d);
    req_valid = 1;
    req_kind = k;
    req_data = d;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (req_ready === 1'b1) break;
    end
    #1 req_valid = 0;
    @(posedge clock);
    #1;
  endtask : send
  // Waits for bit clocking to start and finish
  task automatic wait_conv();
    for (i = 0; i < 30 && busy !== 1'b1; i++) @(posedge clock);
    for (i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clock);
    `CHK("conversion end", 1'b0, busy)
    repeat (3) @(posedge clock);
    #1;
  endtask : wait_conv
  // Receiver stalls at random, so the word buffer must hold back
  always @(posedge clock) #1 word_ready = $urandom % 2;
  // Word monitor takes the oldest expected word
  always @(posedge clock) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) begin
      w_exp = exp_word.size() ? exp_word.pop_front() : 16'hXXXX;
      `CHK("word", w_exp, word_data)
    end
    if (sense_valid === 1'b1) begin
      s_exp = exp_sense.size() ? exp_sense.pop_front() : 1'bx;
      `CHK("sense", s_exp, sense_value)
    end
  end
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    {rst, req_valid, bic_connect, bic_disconnect} = 4'h8;
    {comparator_in, external_start, single_cycle_reload_input} = 3'h0;
    {continuous_mode, timer_start_jumper, req_data, req_kind} = 0;
    void'($urandom(95112));
    repeat (3) @(posedge clock);
    #1 rst = 0;
    `CHK("hold_n", 1'b1, hold_n)
    `CHK("busy", 1'b0, busy)
    `CHK("connected", 1'b0, connected)
    repeat (2) @(posedge clock);
    #1;
    // Program controlled: start, sense, read, sense again
    for (t = 0; t < 4; t++) begin
      comparator_in = (t < 2) ? t[0] : $urandom % 2;
      send(REQ_EXC, 16'h0040);
      wait_conv();
      exp_sense.push_back(1'b1);
      send(REQ_SENSE, 16'h0000);
      exp_word.push_back(comparator_in ? 16'h0FFF : 16'hF000);
      send(REQ_DTI, 16'h0000);
      exp_sense.push_back(1'b0);
      send(REQ_SENSE, 16'h0000);
    end
    $display("test program transfer done");
    // Controller mode, external starts
    send(REQ_EXC, 16'h0080);
    send(REQ_EXC, 16'h0000);
    bic_connect = 1;
    for (i = 0; i < 50 && connected !== 1'b1; i++) @(posedge clock);
    #1 `CHK("connected", 1'b1, connected)
    bic_connect = 0;
    for (t = 0; t < 3; t++) begin
      comparator_in = $urandom % 2;
      exp_word.push_back(comparator_in ? 16'h0FFF : 16'hF000);
      external_start = 1;
      repeat (4) @(posedge clock);
      #1 external_start = 0;
      wait_conv();
      repeat (20) @(posedge clock);
      #1;
    end
    bic_disconnect = 1;
    @(posedge clock);
    #1 bic_disconnect = 0;
    repeat (3) @(posedge clock);
    #1 `CHK("connected", 1'b0, connected)
    external_start = 1;
    repeat (4) @(posedge clock);
    #1 external_start = 0;
    repeat (4) @(posedge clock);
    #1 `CHK("hold_n", 1'b1, hold_n)
    $display("test controller transfer done");
    // Timer: load, expiry seen by the third sense, reload clears
    send(REQ_DTO, 16'h0005);
    exp_sense.push_back(1'b0);
    send(REQ_SENSE, 16'h0040);
    repeat (40) @(posedge clock);
    #1;
    exp_sense.push_back(1'b0);
    send(REQ_SENSE, 16'h0040);
    exp_sense.push_back(1'b1);
    send(REQ_SENSE, 16'h0040);
    send(REQ_DTO, 16'h0005);
    exp_sense.push_back(1'b0);
    send(REQ_SENSE, 16'h0040);
    $display("test timer done");
    repeat (50) @(posedge clock);
    #1 `CHK("words left", 0, exp_word.size())
    `CHK("senses left", 0, exp_sense.size())
    complete_run();
  end
endmodule : test_adc_host_interface_timer
